// ===== rtl/mc_pkg.sv
// Constants for the multichannel element selection block.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package mc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_PORT = 5'h00;
    localparam logic [4:0] OFS_MCR = 5'h04;
    localparam logic [4:0] OFS_RXEN = 5'h08;
    localparam logic [4:0] OFS_TXEN = 5'h0C;
    localparam logic [4:0] OFS_TXBUF = 5'h10;
    localparam logic [4:0] OFS_RXDATA = 5'h14;
    localparam logic [4:0] OFS_FRAME = 5'h18;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int P_RXIM = 0;
    localparam int P_TXIM = 4;
    localparam int P_RXRUN = 16;
    localparam int P_TXRUN = 17;
    localparam int P_RXRDY = 24;
    localparam int P_TXRDY = 25;
    localparam int P_TXEMP = 26;
    localparam int P_RXMC = 0;
    localparam int P_RXCUR = 2;
    localparam int P_RXPA = 5;
    localparam int P_RXPB = 7;
    localparam int P_TXMODE = 16;
    localparam int P_TXCUR = 18;
    localparam int P_TXPA = 21;
    localparam int P_TXPB = 23;
    localparam int P_FLEN = 0;
    localparam int P_WLEN = 8;

    // ****************************************
    // Frame geometry and timing
    // ****************************************
    localparam int ELEM_W = 7;
    localparam int SUBF_LSB = 4;
    localparam int SUBF_W = 3;
    localparam logic [3:0] LAST_IN_SUBF = 4'hF;
    localparam logic [6:0] SUB_ELEMS = 7'h10;
    localparam logic [4:0] WORD_MSB = 5'h1F;
    localparam logic [1:0] IRQ_PULSE = 2'h2;

    // ****************************************
    // Modes
    // ****************************************
    localparam logic [1:0] TXM_ALL = 2'h0;
    localparam logic [1:0] TXM_SEL = 2'h1;
    localparam logic [1:0] TXM_MASK = 2'h2;
    localparam logic [1:0] TXM_SYM = 2'h3;
    localparam logic [1:0] IM_ELEM = 2'h0;
    localparam logic [1:0] IM_SUBF = 2'h1;

    typedef enum logic {FR_IDLE, FR_ACTIVE} frame_t;

endpackage : mc_pkg

// ===== rtl/sel_if.sv
// Carrier between the sequencer and an element selection decoder.
// Assumes the sequencer drives the element index and the selection setup.
interface sel_if;
    logic [6:0] elem;
    logic [1:0] blk_a;
    logic [1:0] blk_b;
    logic [31:0] en;
    logic sel;
    logic [2:0] cur_blk;
    modport user (output elem, blk_a, blk_b, en, input sel, cur_blk);
    modport dec (input elem, blk_a, blk_b, en, output sel, cur_blk);
endinterface : sel_if

// ===== rtl/chan_select.sv
// Decides whether one frame element is selected by the partition blocks.
// Assumes enables hold partition A in the low half, partition B above.
module chan_select (
    // Selection carrier
    sel_if.dec s
);

    function automatic logic [2:0] subframe_of(input logic [6:0] e);
        return e[mc_pkg::SUBF_LSB +: mc_pkg::SUBF_W];
    endfunction : subframe_of

    logic [2:0] sf;
    logic odd;
    logic match;

    always_comb begin
        sf = subframe_of(s.elem);
        odd = sf[0];
        // Even subframes go to A, odd to B; block k covers subframe 2k+odd
        match = odd ? (sf[2:1] == s.blk_b) : (sf[2:1] == s.blk_a);
        s.sel = match & s.en[{odd, s.elem[3:0]}];
        s.cur_blk = sf;
    end

endmodule : chan_select

// ===== rtl/mc_select_top.sv
// Multichannel element selection for a TDM serial port, Avalon-MM slave.
// Assumes bit clock, frame sync and receive data arrive asynchronously.
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
module mc_select_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic [1:0] avs_response_o,
    output logic avs_waitrequest_o,
    // Serial link
    input wire logic bit_clk_i,
    input wire logic frame_sync_i,
    input wire logic rx_data_pin_i,
    output logic tx_data_pin_o,
    output logic tx_data_pin_oe_o,
    // Events
    output logic rx_interrupt_o,
    output logic tx_interrupt_o
);

    typedef struct packed {
        logic sclk1;
        logic sclk2;
        logic sclk3;
        logic fs1;
        logic fs2;
        logic rxd1;
        logic rxd2;
        mc_pkg::frame_t fr;
        logic [6:0] elem;
        logic [4:0] bitc;
        logic [31:0] rx_sh;
        logic [31:0] tx_sh;
        logic tx_drv;
        logic rx_take;
        logic rx_run;
        logic tx_run;
        logic [1:0] rx_im;
        logic [1:0] tx_im;
        logic rx_mc;
        logic [1:0] rx_pa;
        logic [1:0] rx_pb;
        logic [1:0] tx_mode;
        logic [1:0] tx_pa;
        logic [1:0] tx_pb;
        logic [31:0] rx_en;
        logic [31:0] tx_en;
        logic [31:0] tx_buf;
        logic [31:0] rx_dat;
        logic [6:0] flen;
        logic [4:0] wlen;
        logic rx_rdy;
        logic tx_rdy;
        logic tx_emp;
        logic [1:0] rx_ic;
        logic [1:0] tx_ic;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] resp;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ****************************************
    // Element sequencing terms
    // ****************************************
    logic rise;
    logic fs_start;
    logic elem_end;
    logic last_elem;
    logic start_ev;
    logic [6:0] nidx;
    logic acc;
    logic wr_done;
    logic rd_done;
    logic lock_rx;
    logic lock_tx;
    logic tx_copy;
    logic [31:0] rb;
    logic [31:0] w;
    logic [31:0] rx_new;

    sel_if rx_s ();
    sel_if tx_s ();

    assign rise = st_r.sclk2 & ~st_r.sclk3;
    assign fs_start = rise & st_r.fs2 & (st_r.rx_run | st_r.tx_run);
    assign elem_end = rise & (st_r.fr == mc_pkg::FR_ACTIVE) & (st_r.bitc == st_r.wlen);
    assign last_elem = st_r.elem == st_r.flen;
    assign start_ev = fs_start | (elem_end & ~last_elem);
    assign nidx = fs_start ? '0 : 7'(st_r.elem + 7'h01);
    assign acc = (avs_read_i | avs_write_i) & ~st_r.ack;
    assign wr_done = avs_write_i & st_r.ack;
    assign rd_done = avs_read_i & st_r.ack;
    // Frames of one subframe always address the current block
    assign lock_rx = st_r.rx_run & (st_r.flen < mc_pkg::SUB_ELEMS);
    assign lock_tx = st_r.tx_run & (st_r.flen < mc_pkg::SUB_ELEMS);

    // ****************************************
    // Selection decoders
    // ****************************************
    assign rx_s.elem = nidx;
    assign rx_s.blk_a = st_r.rx_pa;
    assign rx_s.blk_b = st_r.rx_pb;
    assign rx_s.en = st_r.rx_en;
    assign tx_s.elem = nidx;
    assign tx_s.blk_a = (st_r.tx_mode == mc_pkg::TXM_SYM) ? st_r.rx_pa : st_r.tx_pa;
    assign tx_s.blk_b = (st_r.tx_mode == mc_pkg::TXM_SYM) ? st_r.rx_pb : st_r.tx_pb;
    assign tx_s.en = st_r.tx_en;

    chan_select u_rx_sel (
        .s(rx_s)
    );

    chan_select u_tx_sel (
        .s(tx_s)
    );

    always_comb begin
        case (st_r.tx_mode)
            mc_pkg::TXM_ALL: tx_copy = 1'b1;
            mc_pkg::TXM_SEL: tx_copy = tx_s.sel;
            mc_pkg::TXM_MASK: tx_copy = 1'b1;
            mc_pkg::TXM_SYM: tx_copy = rx_s.sel;
            default: tx_copy = 1'b1;
        endcase
    end

    // ****************************************
    // Register readback
    // ****************************************
    always_comb begin
        rb = '0;
        case (avs_address_i)
            mc_pkg::OFS_PORT: begin
                rb[mc_pkg::P_RXIM +: 2] = st_r.rx_im;
                rb[mc_pkg::P_TXIM +: 2] = st_r.tx_im;
                rb[mc_pkg::P_RXRUN] = st_r.rx_run;
                rb[mc_pkg::P_TXRUN] = st_r.tx_run;
                rb[mc_pkg::P_RXRDY] = st_r.rx_rdy;
                rb[mc_pkg::P_TXRDY] = st_r.tx_rdy;
                rb[mc_pkg::P_TXEMP] = st_r.tx_emp;
            end
            mc_pkg::OFS_MCR: begin
                rb[mc_pkg::P_RXMC] = st_r.rx_mc;
                rb[mc_pkg::P_RXPA +: 2] = st_r.rx_pa;
                rb[mc_pkg::P_RXPB +: 2] = st_r.rx_pb;
                rb[mc_pkg::P_TXMODE +: 2] = st_r.tx_mode;
                rb[mc_pkg::P_TXPA +: 2] = st_r.tx_pa;
                rb[mc_pkg::P_TXPB +: 2] = st_r.tx_pb;
                if (st_r.rx_run) begin
                    rb[mc_pkg::P_RXCUR +: 3] = st_r.elem[mc_pkg::SUBF_LSB +: 3];
                end
                if (st_r.tx_run) begin
                    rb[mc_pkg::P_TXCUR +: 3] = st_r.elem[mc_pkg::SUBF_LSB +: 3];
                end
            end
            mc_pkg::OFS_RXEN: rb = st_r.rx_en;
            mc_pkg::OFS_TXEN: rb = st_r.tx_en;
            mc_pkg::OFS_TXBUF: rb = st_r.tx_buf;
            mc_pkg::OFS_RXDATA: rb = st_r.rx_dat;
            mc_pkg::OFS_FRAME: begin
                rb[mc_pkg::P_FLEN +: 7] = st_r.flen;
                rb[mc_pkg::P_WLEN +: 5] = st_r.wlen;
            end
            default: rb = '0;
        endcase
        w = merge(rb, avs_writedata_i, avs_byteenable_i);
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.sclk1 = bit_clk_i;
        st_nxt.sclk2 = st_r.sclk1;
        st_nxt.sclk3 = st_r.sclk2;
        st_nxt.fs1 = frame_sync_i;
        st_nxt.fs2 = st_r.fs1;
        st_nxt.rxd1 = rx_data_pin_i;
        st_nxt.rxd2 = st_r.rxd1;
        rx_new = {st_r.rx_sh[30:0], st_r.rxd2};

        // Bus slave: one wait cycle, effects at the completing edge
        st_nxt.ack = acc;
        if (acc) begin
            st_nxt.rdata = rb;
            st_nxt.resp = (avs_address_i > mc_pkg::OFS_FRAME || avs_address_i[1:0] != 2'h0) ?
                          mc_pkg::RESP_SLVERR : mc_pkg::RESP_OK;
        end
        if (rd_done && avs_address_i == mc_pkg::OFS_RXDATA) begin
            st_nxt.rx_rdy = 1'b0;
        end
        if (wr_done) begin
            case (avs_address_i)
                mc_pkg::OFS_PORT: begin
                    st_nxt.rx_im = w[mc_pkg::P_RXIM +: 2];
                    st_nxt.tx_im = w[mc_pkg::P_TXIM +: 2];
                    st_nxt.rx_run = w[mc_pkg::P_RXRUN];
                    st_nxt.tx_run = w[mc_pkg::P_TXRUN];
                end
                mc_pkg::OFS_MCR: begin
                    st_nxt.rx_mc = w[mc_pkg::P_RXMC];
                    st_nxt.tx_mode = w[mc_pkg::P_TXMODE +: 2];
                    if (!lock_rx) begin
                        st_nxt.rx_pa = w[mc_pkg::P_RXPA +: 2];
                        st_nxt.rx_pb = w[mc_pkg::P_RXPB +: 2];
                    end
                    if (!lock_tx) begin
                        st_nxt.tx_pa = w[mc_pkg::P_TXPA +: 2];
                        st_nxt.tx_pb = w[mc_pkg::P_TXPB +: 2];
                    end
                end
                mc_pkg::OFS_RXEN: if (!lock_rx) st_nxt.rx_en = w;
                mc_pkg::OFS_TXEN: if (!lock_tx) st_nxt.tx_en = w;
                mc_pkg::OFS_TXBUF: begin
                    st_nxt.tx_buf = w;
                    st_nxt.tx_rdy = 1'b0;
                    st_nxt.tx_emp = 1'b0;
                end
                mc_pkg::OFS_FRAME: begin
                    st_nxt.flen = w[mc_pkg::P_FLEN +: 7];
                    st_nxt.wlen = w[mc_pkg::P_WLEN +: 5];
                end
                default: st_nxt.ack = st_nxt.ack;
            endcase
        end

        if (st_r.rx_ic != '0) st_nxt.rx_ic = st_r.rx_ic - 2'h1;
        if (st_r.tx_ic != '0) st_nxt.tx_ic = st_r.tx_ic - 2'h1;

        // Bit timing on the rising bit clock edge
        if (rise && st_r.fr == mc_pkg::FR_ACTIVE) begin
            st_nxt.rx_sh = rx_new;
            st_nxt.tx_sh = {st_r.tx_sh[30:0], 1'b0};
            st_nxt.bitc = 5'(st_r.bitc + 5'h01);
        end
        if (elem_end) begin
            st_nxt.bitc = '0;
            if (st_r.rx_run && st_r.rx_take) begin
                st_nxt.rx_dat = rx_new & ({32{1'b1}} >> (mc_pkg::WORD_MSB - st_r.wlen));
                st_nxt.rx_rdy = 1'b1;
                if (st_r.rx_im == mc_pkg::IM_ELEM) st_nxt.rx_ic = mc_pkg::IRQ_PULSE;
            end
            if (st_r.elem[3:0] == mc_pkg::LAST_IN_SUBF || last_elem) begin
                if (st_r.rx_run && st_r.rx_mc && st_r.rx_im == mc_pkg::IM_SUBF) begin
                    st_nxt.rx_ic = mc_pkg::IRQ_PULSE;
                end
                if (st_r.tx_run && st_r.tx_mode != mc_pkg::TXM_ALL
                    && st_r.tx_im == mc_pkg::IM_SUBF) begin
                    st_nxt.tx_ic = mc_pkg::IRQ_PULSE;
                end
            end
            if (last_elem) begin
                st_nxt.fr = mc_pkg::FR_IDLE;
                st_nxt.tx_drv = 1'b0;
            end else begin
                st_nxt.elem = nidx;
            end
        end
        if (fs_start) begin
            st_nxt.fr = mc_pkg::FR_ACTIVE;
            st_nxt.elem = '0;
            st_nxt.bitc = '0;
        end

        // Element start: copy and drive decisions for element nidx
        if (start_ev) begin
            st_nxt.rx_take = ~st_r.rx_mc | rx_s.sel;
            st_nxt.tx_drv = st_r.tx_run
                            & ((st_r.tx_mode == mc_pkg::TXM_ALL) | tx_s.sel);
            if (st_r.tx_run && tx_copy) begin
                st_nxt.tx_sh = st_r.tx_buf << (mc_pkg::WORD_MSB - st_r.wlen);
                if (st_r.tx_rdy) st_nxt.tx_emp = 1'b1;
                st_nxt.tx_rdy = 1'b1;
                if (st_r.tx_im == mc_pkg::IM_ELEM) st_nxt.tx_ic = mc_pkg::IRQ_PULSE;
            end
        end
        if (!st_r.tx_run) begin
            st_nxt.tx_drv = 1'b0;
            st_nxt.tx_rdy = 1'b1;
            st_nxt.tx_emp = 1'b1;
        end
        if (!st_r.rx_run && !st_r.tx_run) st_nxt.fr = mc_pkg::FR_IDLE;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~st_r.ack;
    assign avs_readdata_o = st_r.rdata;
    assign avs_response_o = st_r.resp;
    assign tx_data_pin_o = st_r.tx_sh[mc_pkg::WORD_MSB];
    assign tx_data_pin_oe_o = st_r.tx_drv & (st_r.fr == mc_pkg::FR_ACTIVE);
    assign rx_interrupt_o = st_r.rx_ic != '0;
    assign tx_interrupt_o = st_r.tx_ic != '0;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_rx_two;
        rx_interrupt_o [*2] ##1 !rx_interrupt_o;
    endsequence
    sequence s_tx_two;
        tx_interrupt_o [*2] ##1 !tx_interrupt_o;
    endsequence

    a_rx_irq_pulse: assert property ($rose(rx_interrupt_o) |-> s_rx_two)
        else $error("rx interrupt pulse not two cycles");
    a_tx_irq_pulse: assert property ($rose(tx_interrupt_o) |-> s_tx_two)
        else $error("tx interrupt pulse not two cycles");
    a_subf_irq_rx: assert property (elem_end && st_r.elem[3:0] == mc_pkg::LAST_IN_SUBF
        && st_r.rx_run && st_r.rx_mc && st_r.rx_im == mc_pkg::IM_SUBF |=> s_rx_two)
        else $error("missing subframe interrupt");
    a_no_irq_plain: assert property ($rose(rx_interrupt_o) && $past(st_r.rx_im)
        == mc_pkg::IM_SUBF |-> $past(st_r.rx_mc))
        else $error("subframe interrupt without multichannel");
    a_idle_hiz: assert property (st_r.fr == mc_pkg::FR_IDLE |-> !st_r.tx_drv)
        else $error("pin driven between packets");
    a_mode_all_drive: assert property (start_ev && st_r.tx_run
        && st_r.tx_mode == mc_pkg::TXM_ALL |=> tx_data_pin_oe_o)
        else $error("mode 00 element not driven");
    a_unsel_hiz: assert property (start_ev && st_r.tx_mode != mc_pkg::TXM_ALL
        && !tx_s.sel |=> !tx_data_pin_oe_o)
        else $error("unselected element driven");
    a_rx_skip: assert property (elem_end && !st_r.rx_take |=> $stable(st_r.rx_dat))
        else $error("unselected receive element copied");
    a_tx_skip: assert property (start_ev && st_r.tx_run && !tx_copy && !wr_done
        |=> $stable(st_r.tx_rdy) && $stable(st_r.tx_emp))
        else $error("unselected transmit element touched flags");
    a_sym_copy: assert property (start_ev && st_r.tx_run && st_r.tx_mode ==
        mc_pkg::TXM_SYM && rx_s.sel && !wr_done |=> st_r.tx_rdy)
        else $error("symmetric copy missing");
    a_short_lock: assert property (wr_done && avs_address_i == mc_pkg::OFS_RXEN
        && lock_rx |=> $stable(st_r.rx_en))
        else $error("enables changed in short frame");

endmodule : mc_select_top

// ===== dv/tdm_line.sv
// Far side of the TDM line: bit clock, frame sync and receive data.
// Assumes the bench fills rx_word before a frame and reads the captures after.
module tdm_line #(
    parameter int NELEM = 32,
    parameter int WBITS = 4
) (
    // Link lines
    output logic bit_clk_o,
    output logic frame_sync_o,
    output logic rx_data_o,
    input wire logic tx_data_i,
    input wire logic tx_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [WBITS-1:0] rx_word [NELEM];
    logic [WBITS-1:0] tx_word [NELEM];
    logic [WBITS-1:0] oe_word [NELEM];
    int elem_idx;
    initial begin
        bit_clk_o = 1'b0;
        frame_sync_o = 1'b0;
        rx_data_o = 1'b1;
        elem_idx = 0;
    end
    // ****************************************
    // One frame; the clock stands still outside it
    // ****************************************
    task run_frame();
        int j;
        frame_sync_o = 1'b1;
        #40;
        for (j = 0; j < NELEM * WBITS; j++) begin
            bit_clk_o = 1'b1;
            elem_idx = j / WBITS;
            #40;
            bit_clk_o = 1'b0;
            frame_sync_o = 1'b0;
            tx_word[j / WBITS][WBITS - 1 - j % WBITS] = tx_data_i;
            oe_word[j / WBITS][WBITS - 1 - j % WBITS] = tx_oe_i;
            rx_data_o = rx_word[j / WBITS][WBITS - 1 - j % WBITS];
            #40;
        end
        bit_clk_o = 1'b1;
        #40;
        bit_clk_o = 1'b0;
        rx_data_o = ~rx_data_o;
    endtask : run_frame
endmodule : tdm_line

// ===== dv/tb.sv
// Self-checking bench: random selections, frames from the line model.
// Assumes the selection block and its package are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [31:0] avs_readdata_o;
    logic [1:0] avs_response_o;
    logic avs_waitrequest_o;
    logic bit_clk, fsync, rxd, txd, txoe, rx_int, tx_int;
    logic [31:0] lfsr_r = 32'h00000045;
    logic [31:0] q, rxen, txen, multichannel_control_reg, port, buf_v, last_rx;
    logic [1:0] r, txm;
    logic drv [32];
    int n_mismatch = 0, check_count = 0, f, e, ncp_rx, ncp_tx, n_ri, n_ti, rw = 0, tw = 0;
    always #4 clk_i = ~clk_i;
    mc_select_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
        .avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o),
        .bit_clk_i(bit_clk), .frame_sync_i(fsync), .rx_data_pin_i(rxd), .tx_data_pin_o(txd),
        .tx_data_pin_oe_o(txoe), .rx_interrupt_o(rx_int), .tx_interrupt_o(tx_int));
    tdm_line u_line (.bit_clk_o(bit_clk), .frame_sync_o(fsync), .rx_data_o(rxd),
        .tx_data_i(txd), .tx_oe_i(txoe));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) begin
            lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        end
        return lfsr_r;
    endfunction : rnd
    function automatic logic sel(int el, logic [1:0] pa, logic [1:0] pb, logic [31:0] en);
        int s;
        s = el / 16;
        return ((s % 2 == 1) ? (s / 2 == pb) : (s / 2 == pa)) && en[16 * (s % 2) + el % 16];
    endfunction : sel
    task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic [1:0] rs);
        logic done;
        done = 1'b0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        while (!done) begin
            // Settled value that stands at the coming rising edge
            @(negedge clk_i);
            done = (avs_waitrequest_o === 1'b0);
            rd = avs_readdata_o;
            rs = avs_response_o;
            @(posedge clk_i);
        end
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus
    task report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // ****************************************
    // Interrupt pulse monitor
    // ****************************************
    always @(negedge clk_i) begin
        if (rx_int === 1'b1) begin
            rw++;
        end else if (rw != 0) begin
            check("rx_pulse_width", 2, rw);
            n_ri++;
            rw = 0;
        end
        if (tx_int === 1'b1) begin
            tw++;
        end else if (tw != 0) begin
            check("tx_pulse_width", 2, tw);
            n_ti++;
            tw = 0;
        end
    end
    initial begin
        #300000;
        n_mismatch++;
        report_and_stop();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        last_rx = 32'h00000000;
        bus(1'b1, mc_pkg::OFS_FRAME, 32'h0000031F, q, r);
        for (f = 0; f < 8; f++) begin
            multichannel_control_reg = rnd() & 32'h00A300A1;
            txm = multichannel_control_reg[17:16];
            multichannel_control_reg[0] = multichannel_control_reg[0] | (txm == mc_pkg::TXM_SYM);
            rxen = rnd();
            txen = rnd();
            if (txm == mc_pkg::TXM_SYM) txen = txen & rxen;
            port = 32'h00030000 | (rnd() & 32'h00000011);
            buf_v = rnd();
            bus(1'b1, mc_pkg::OFS_PORT, port, q, r);
            bus(1'b1, mc_pkg::OFS_MCR, multichannel_control_reg, q, r);
            bus(1'b1, mc_pkg::OFS_RXEN, rxen, q, r);
            bus(1'b1, mc_pkg::OFS_TXEN, txen, q, r);
            bus(1'b1, mc_pkg::OFS_TXBUF, buf_v, q, r);
            bus(1'b0, mc_pkg::OFS_MCR, 32'h00000000, q, r);
            check("mcr", multichannel_control_reg, q & 32'h01E301E1);
            ncp_rx = 0;
            ncp_tx = 0;
            for (e = 0; e < 32; e++) begin
                q = rnd();
                u_line.rx_word[e] = q[3:0];
                if (!multichannel_control_reg[0] || sel(e, multichannel_control_reg[6:5], multichannel_control_reg[8:7], rxen)) begin
                    ncp_rx++;
                    last_rx = {28'h0000000, q[3:0]};
                end
                if (txm == mc_pkg::TXM_ALL || txm == mc_pkg::TXM_MASK) ncp_tx++;
                else if (txm == mc_pkg::TXM_SYM) ncp_tx += sel(e, multichannel_control_reg[6:5], multichannel_control_reg[8:7], rxen);
                else ncp_tx += sel(e, multichannel_control_reg[22:21], multichannel_control_reg[24:23], txen);
                drv[e] = (txm == mc_pkg::TXM_ALL) ? 1'b1 : (txm == mc_pkg::TXM_SYM) ?
                    sel(e, multichannel_control_reg[6:5], multichannel_control_reg[8:7], txen) : sel(e, multichannel_control_reg[22:21], multichannel_control_reg[24:23], txen);
            end
            n_ri = 0;
            n_ti = 0;
            fork
                u_line.run_frame();
                begin
                    wait (u_line.elem_idx == 20);
                    bus(1'b0, mc_pkg::OFS_MCR, 32'h00000000, q, r);
                    check("rx_current_block", 1, q[4:2]);
                    check("tx_current_block", 1, q[20:18]);
                    bus(1'b1, mc_pkg::OFS_MCR, multichannel_control_reg ^ 32'h00200020, q, r);
                end
            join
            repeat (10) @(posedge clk_i);
            bus(1'b0, mc_pkg::OFS_MCR, 32'h00000000, q, r);
            check("mcr_pingpong", multichannel_control_reg ^ 32'h00200020, q & 32'h01E301E1);
            for (e = 0; e < 32; e++) begin
                check("tx_oe", drv[e] ? 4'hF : 4'h0, u_line.oe_word[e]);
                if (drv[e]) check("tx_bits", buf_v[3:0], u_line.tx_word[e]);
            end
            check("tx_oe_idle", 0, txoe);
            check("rx_irqs", port[1:0] == 2'h0 ? ncp_rx : (multichannel_control_reg[0] ? 2 : 0), n_ri);
            check("tx_irqs", port[5:4] == 2'h0 ? ncp_tx : (txm != 2'h0 ? 2 : 0), n_ti);
            bus(1'b0, mc_pkg::OFS_PORT, 32'h00000000, q, r);
            check("flags", {ncp_tx > 1, ncp_tx > 0, ncp_rx > 0}, q[26:24]);
            bus(1'b0, mc_pkg::OFS_RXDATA, 32'h00000000, q, r);
            check("rx_data", last_rx, q);
        end
        bus(1'b1, mc_pkg::OFS_FRAME, 32'h0000030F, q, r);
        bus(1'b1, mc_pkg::OFS_RXEN, ~rxen, q, r);
        bus(1'b0, mc_pkg::OFS_RXEN, 32'h00000000, q, r);
        check("short_frame_lock", rxen, q);
        bus(1'b0, 5'h1C, 32'h00000000, q, r);
        check("unmapped_resp", mc_pkg::RESP_SLVERR, r);
        check("unmapped_data", 0, q);
        report_and_stop();
    end
endmodule : tb
